// ---- sfc_params.svh ----
// Purpose: offsets, field positions, reset values
// Assumes: printed offsets are register indices
// Notes:   byte address is four times the index
`ifndef SFC_PARAMS_SVH
`define SFC_PARAMS_SVH

////////////////////////////////////////////////////////////////
// register indices (byte address = index * 4)
`define SFC_IDX_TX_CTRL   16'h705a
`define SFC_IDX_RX_CTRL   16'h705b
`define SFC_IDX_TX_DATA   16'h7060
`define SFC_IDX_RX_DATA   16'h7061
`define SFC_IDX_IRQ_STAT  16'h7062
`define SFC_IDX_IRQ_MASK  16'h7063

////////////////////////////////////////////////////////////////
// transmit control fields
`define SFC_TX_SOFT_RST   15
`define SFC_TX_ENHANCE    14
`define SFC_TX_QRST       13
`define SFC_LEVEL_HI      12
`define SFC_LEVEL_LO      8
`define SFC_FLAG          7
`define SFC_CLEAR         6
`define SFC_IENA          5
`define SFC_THR_HI        4
`define SFC_THR_LO        0
// receive control fields
`define SFC_RX_OVF        15
`define SFC_RX_OVF_CLR    14
`define SFC_RX_QRST       13

////////////////////////////////////////////////////////////////
// reset values
`define SFC_RST_TX_THR    5'h00
`define SFC_RST_RX_THR    5'h1f
`define SFC_RST_MASK      3'h0

`endif

// ---- sfc_pkg.sv ----
// Purpose: shared types of the serial port queue control
// Assumes: nothing beyond the parameter header
// Notes:   one-hot codes for the bus handshake
package sfc_pkg;

    // avalon handshake phase
    typedef enum logic [1:0] {
        SFC_BUS_IDLE = 2'b01,
        SFC_BUS_ACK  = 2'b10
    } sfc_bus_state_type;

    // interrupt status bit positions
    typedef enum logic [1:0] {
        SFC_EV_TX  = 2'd0,
        SFC_EV_RX  = 2'd1,
        SFC_EV_OVF = 2'd2
    } sfc_event_type;

endpackage

// ---- sfc_queue.sv ----
// Purpose: small word queue with flush and overwrite-oldest
// Assumes: DEPTH is a power of two
// Notes:   cap_i narrows usable depth, e.g. to one word
`timescale 1ns/1ps
module sfc_queue
    import sfc_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4,
    parameter int CW    = $clog2(DEPTH + 1)
)
(
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    // control
    input  wire logic             flush_i,
    input  wire logic [CW-1:0]    cap_i,
    // fill side
    input  wire logic             push_i,
    input  wire logic [WIDTH-1:0] data_i,
    // drain side
    input  wire logic             pop_i,
    output logic [WIDTH-1:0]      head_o,
    output logic [CW-1:0]         count_o,
    output logic                  drop_o
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               rd_ptr;
        logic [CW-1:0]               count;
    } sfc_queue_state_type;

    sfc_queue_state_type s;
    sfc_queue_state_type next_s;
    logic                do_pop;
    logic                do_drop;
    logic [PW-1:0]       wr_ptr;

    ////////////////////////////////////////////////////////////
    // pointer and count update; a full push drops the oldest word
    always_comb
    begin
        next_s  = s;
        do_pop  = pop_i && (s.count != '0);
        do_drop = push_i && (s.count >= cap_i) && !do_pop;
        wr_ptr  = PW'(s.rd_ptr + PW'(s.count));
        if (flush_i)
        begin
            next_s.rd_ptr = '0;
            next_s.count  = '0;
            do_drop       = 1'b0;
        end
        else
        begin
            if (push_i)
                next_s.mem[wr_ptr] = data_i;
            if (do_pop || do_drop)
                next_s.rd_ptr = PW'(s.rd_ptr + 1'b1);
            if (push_i && !do_drop && !do_pop)
                next_s.count = CW'(s.count + 1'b1);
            else if (do_pop && !push_i)
                next_s.count = CW'(s.count - 1'b1);
        end
    end

    // state register
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            s <= '0;
        else
            s <= next_s;
    end

    assign head_o  = s.mem[s.rd_ptr];
    assign count_o = s.count;
    assign drop_o  = do_drop;
endmodule

// ---- sfc_top.sv ----
// Purpose: control and status of the serial port tx/rx queues
// Assumes: avalon-mm slave, byte addresses, 32-bit data
// Notes:   one wait cycle on every access
`timescale 1ns/1ps
`include "sfc_params.svh"

// Function
// - writing 0 to channel_soft_reset flushes both channels, config kept.
// - queue_enhance_enable 1 gives full queues, 0 gives single-word buffering.
// - tx_queue_reset 0 holds the tx pointer at zero; 1 resumes.
// - tx_queue_level reports tx word count, 0 to 4, binary.
// - tx_queue_irq_flag is read-only and shows a past tx condition.
// - tx_queue_irq_clear write 1 clears the flag; reads back zero.
// - tx_queue_irq_enable gates the tx level interrupt.
// - tx condition raised while queue_enhance_enable is 1 and tx level <= tx_queue_threshold.
// - rx control layout: overrun, clear, reset, level, flag, clear, enable, threshold.
// - rx overrun sets when a word arrives into a full queue; oldest lost.
// - rx_queue_level reports rx word count, 0 to 4, binary.
// - rx_queue_reset 0 holds the rx pointer at zero; 1 resumes.
// - rx_queue_irq_clear write 1 clears the rx flag; 0 no effect.
module sfc_top
    import sfc_pkg::*;
#(
    parameter int DEPTH = 4,
    parameter int WIDTH = 8
)
(
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    // avalon-mm slave
    input  wire logic [17:0]      avs_address_i,
    input  wire logic             avs_read_i,
    input  wire logic             avs_write_i,
    input  wire logic [3:0]       avs_byteenable_i,
    input  wire logic [31:0]      avs_writedata_i,
    output logic [31:0]           avs_readdata_o,
    output logic                  avs_waitrequest_o,
    // transmit word stream toward the shifter
    output logic [WIDTH-1:0]      tx_data_o,
    output logic                  tx_valid_o,
    input  wire logic             tx_ready_i,
    // receive word stream from the shifter
    input  wire logic [WIDTH-1:0] rx_data_i,
    input  wire logic             rx_valid_i,
    // interrupts
    output logic                  tx_irq_o,
    output logic                  rx_irq_o,
    output logic                  irq_o
);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        sfc_bus_state_type bus;
        logic              wait_req;
        logic [31:0]       rdata;
        // transmit control
        logic              channel_soft_reset;
        logic              queue_enhance_enable;
        logic              tx_queue_reset;
        logic              tx_queue_irq_flag;
        logic              tx_queue_irq_enable;
        logic [4:0]        tx_queue_threshold;
        // receive control
        logic              rx_queue_overrun;
        logic              rx_queue_reset;
        logic              rx_queue_irq_flag;
        logic              rx_queue_irq_enable;
        logic [4:0]        rx_queue_threshold;
        // output stage and interrupts
        logic [WIDTH-1:0]  tx_data;
        logic              tx_valid;
        logic [2:0]        irq_status;
        logic [2:0]        irq_mask;
        logic              tx_irq;
        logic              rx_irq;
        logic              irq;
    } sfc_state_type;

    sfc_state_type    s;
    sfc_state_type    next_s;

    // queue connections
    logic             tx_flush;
    logic             rx_flush;
    logic [CW-1:0]    cap;
    logic             tx_push;
    logic             tx_pop;
    logic             rx_pop;
    logic [WIDTH-1:0] tx_head;
    logic [WIDTH-1:0] rx_head;
    logic [CW-1:0]    tx_count;
    logic [CW-1:0]    rx_count;
    logic             rx_drop;

    // bus decode helpers
    logic [15:0]      idx;
    logic             req;
    logic             commit;
    logic             wr_lo;
    logic             wr_hi;
    logic [4:0]       tx_level;
    logic [4:0]       rx_level;
    logic             tx_cond;
    logic             rx_cond;
    logic [2:0]       events;

    ////////////////////////////////////////////////////////////
    // read value of each register index
    function automatic logic [31:0] read_reg(
        input sfc_state_type st,
        input logic [15:0]   index,
        input logic [4:0]    txl,
        input logic [4:0]    rxl,
        input logic [WIDTH-1:0] rxh
    );
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (index)
            `SFC_IDX_TX_CTRL:
            begin
                v[`SFC_TX_SOFT_RST] = st.channel_soft_reset;
                v[`SFC_TX_ENHANCE]  = st.queue_enhance_enable;
                v[`SFC_TX_QRST]     = st.tx_queue_reset;
                v[`SFC_LEVEL_HI:`SFC_LEVEL_LO] = txl;
                v[`SFC_FLAG]        = st.tx_queue_irq_flag;
                v[`SFC_IENA]        = st.tx_queue_irq_enable;
                v[`SFC_THR_HI:`SFC_THR_LO] = st.tx_queue_threshold;
            end
            `SFC_IDX_RX_CTRL:
            begin
                v[`SFC_RX_OVF]      = st.rx_queue_overrun;
                v[`SFC_RX_QRST]     = st.rx_queue_reset;
                v[`SFC_LEVEL_HI:`SFC_LEVEL_LO] = rxl;
                v[`SFC_FLAG]        = st.rx_queue_irq_flag;
                v[`SFC_IENA]        = st.rx_queue_irq_enable;
                v[`SFC_THR_HI:`SFC_THR_LO] = st.rx_queue_threshold;
            end
            `SFC_IDX_RX_DATA:  v[WIDTH-1:0] = rxh;
            `SFC_IDX_IRQ_STAT: v[2:0] = st.irq_status;
            `SFC_IDX_IRQ_MASK: v[2:0] = st.irq_mask;
            default:           v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////
    // queues
    sfc_queue #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH),
        .CW    (CW)
    ) u_tx_queue (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .flush_i (tx_flush),
        .cap_i   (cap),
        .push_i  (tx_push),
        .data_i  (avs_writedata_i[WIDTH-1:0]),
        .pop_i   (tx_pop),
        .head_o  (tx_head),
        .count_o (tx_count),
        .drop_o  ()
    );

    sfc_queue #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH),
        .CW    (CW)
    ) u_rx_queue (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .flush_i (rx_flush),
        .cap_i   (cap),
        .push_i  (rx_valid_i && !rx_flush),
        .data_i  (rx_data_i),
        .pop_i   (rx_pop),
        .head_o  (rx_head),
        .count_o (rx_count),
        .drop_o  (rx_drop)
    );

    ////////////////////////////////////////////////////////////
    // access decode; effects happen on the edge that ends the wait
    always_comb
    begin
        idx      = avs_address_i[17:2];
        req      = avs_read_i || avs_write_i;
        commit   = req && (s.bus == SFC_BUS_ACK);
        wr_lo    = commit && avs_write_i && avs_byteenable_i[0];
        wr_hi    = commit && avs_write_i && avs_byteenable_i[1];
        // level fields are the binary queue counts
        tx_level = 5'(tx_count);
        rx_level = 5'(rx_count);
        // single-word depth when enhancements are off
        cap      = s.queue_enhance_enable ? CW'(DEPTH) : CW'(1);
        tx_flush = !s.channel_soft_reset || !s.tx_queue_reset;
        rx_flush = !s.channel_soft_reset || !s.rx_queue_reset;
        tx_push  = wr_lo && (idx == `SFC_IDX_TX_DATA) && !tx_flush;
        rx_pop   = commit && avs_read_i && (idx == `SFC_IDX_RX_DATA);
        // output stage reloads when empty or taken
        tx_pop   = (!s.tx_valid || tx_ready_i) && (tx_count != '0)
                   && !tx_flush;
        // tx level at or below threshold
        tx_cond  = s.queue_enhance_enable
                   && (tx_level <= s.tx_queue_threshold);
        rx_cond  = s.queue_enhance_enable && (rx_level != 5'h00)
                   && (rx_level >= s.rx_queue_threshold);
        events   = {rx_drop, rx_cond && !s.rx_queue_irq_flag,
                    tx_cond && !s.tx_queue_irq_flag};
    end

    ////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        next_s = s;

        // one wait cycle, then the access completes
        unique case (s.bus)
            SFC_BUS_IDLE:
            begin
                if (req)
                begin
                    next_s.bus      = SFC_BUS_ACK;
                    next_s.wait_req = 1'b0;
                    next_s.rdata    = avs_read_i
                        ? read_reg(s, idx, tx_level, rx_level, rx_head)
                        : 32'h0000_0000;
                end
            end
            SFC_BUS_ACK:
            begin
                next_s.bus      = SFC_BUS_IDLE;
                next_s.wait_req = 1'b1;
            end
        endcase

        // tx control writes; config bits survive the soft reset
        if (wr_hi && (idx == `SFC_IDX_TX_CTRL))
        begin
            next_s.channel_soft_reset   = avs_writedata_i[`SFC_TX_SOFT_RST];
            next_s.queue_enhance_enable = avs_writedata_i[`SFC_TX_ENHANCE];
            next_s.tx_queue_reset       = avs_writedata_i[`SFC_TX_QRST];
        end
        if (wr_lo && (idx == `SFC_IDX_TX_CTRL))
        begin
            next_s.tx_queue_irq_enable = avs_writedata_i[`SFC_IENA];
            next_s.tx_queue_threshold  =
                avs_writedata_i[`SFC_THR_HI:`SFC_THR_LO];
        end

        // rx control writes
        if (wr_hi && (idx == `SFC_IDX_RX_CTRL))
            next_s.rx_queue_reset = avs_writedata_i[`SFC_RX_QRST];
        if (wr_lo && (idx == `SFC_IDX_RX_CTRL))
        begin
            next_s.rx_queue_irq_enable = avs_writedata_i[`SFC_IENA];
            next_s.rx_queue_threshold  =
                avs_writedata_i[`SFC_THR_HI:`SFC_THR_LO];
        end
        if (wr_lo && (idx == `SFC_IDX_IRQ_MASK))
            next_s.irq_mask = avs_writedata_i[2:0];

        if (wr_lo && (idx == `SFC_IDX_TX_CTRL)
            && avs_writedata_i[`SFC_CLEAR])
            next_s.tx_queue_irq_flag = 1'b0;
        // condition sets the flag, set beats clear
        if (tx_cond)
            next_s.tx_queue_irq_flag = 1'b1;

        if (wr_lo && (idx == `SFC_IDX_RX_CTRL)
            && avs_writedata_i[`SFC_CLEAR])
            next_s.rx_queue_irq_flag = 1'b0;
        if (rx_cond)
            next_s.rx_queue_irq_flag = 1'b1;

        // overrun clear, then set on a dropped word
        if (wr_hi && (idx == `SFC_IDX_RX_CTRL)
            && avs_writedata_i[`SFC_RX_OVF_CLR])
            next_s.rx_queue_overrun = 1'b0;
        if (rx_drop)
            next_s.rx_queue_overrun = 1'b1;

        // output stage toward the shifter
        if (tx_flush)
            next_s.tx_valid = 1'b0;
        else if (tx_pop)
        begin
            next_s.tx_data  = tx_head;
            next_s.tx_valid = 1'b1;
        end
        else if (tx_ready_i)
            next_s.tx_valid = 1'b0;

        // sticky status: a read clears only the bits it returned
        if (commit && avs_read_i && (idx == `SFC_IDX_IRQ_STAT))
            next_s.irq_status = s.irq_status & ~s.rdata[2:0];
        next_s.irq_status = next_s.irq_status | events;

        // interrupt outputs registered
        // tx request follows flag and enable
        next_s.tx_irq = next_s.tx_queue_irq_flag
                        && next_s.tx_queue_irq_enable;
        next_s.rx_irq = next_s.rx_queue_irq_flag
                        && next_s.rx_queue_irq_enable;
        next_s.irq    = |(next_s.irq_status & next_s.irq_mask);
    end

    ////////////////////////////////////////////////////////////
    // state register with documented reset values
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            s                      <= '0;
            s.bus                  <= SFC_BUS_IDLE;
            s.wait_req             <= 1'b1;
            s.channel_soft_reset   <= 1'b1;
            s.tx_queue_reset       <= 1'b1;
            s.rx_queue_reset       <= 1'b1;
            s.tx_queue_threshold   <= `SFC_RST_TX_THR;
            s.rx_queue_threshold   <= `SFC_RST_RX_THR;
            s.irq_mask             <= `SFC_RST_MASK;
        end
        else
        begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////
    // outputs straight from the state register
    assign avs_readdata_o    = s.rdata;
    assign avs_waitrequest_o = s.wait_req;
    assign tx_data_o         = s.tx_data;
    assign tx_valid_o        = s.tx_valid;
    assign tx_irq_o          = s.tx_irq;
    assign rx_irq_o          = s.rx_irq;
    assign irq_o             = s.irq;
endmodule

// ---- sfc_assertions.sv ----
// Purpose: port-level checks of the queue control block
// Assumes: one wait cycle per access, registered irqs
// Notes:   sees only the top-level ports
`timescale 1ns/1ps
`include "sfc_params.svh"
module sfc_assertions
    import sfc_pkg::*;
#(
    parameter int DEPTH = 4,
    parameter int WIDTH = 8
)
(
    // clock and reset
    input wire logic             clk_i,
    input wire logic             rstn_i,
    // register bus
    input wire logic [17:0]      avs_address_i,
    input wire logic             avs_read_i,
    input wire logic             avs_write_i,
    input wire logic [3:0]       avs_byteenable_i,
    input wire logic [31:0]      avs_writedata_i,
    input wire logic [31:0]      avs_readdata_o,
    input wire logic             avs_waitrequest_o,
    // streams
    input wire logic [WIDTH-1:0] tx_data_o,
    input wire logic             tx_valid_o,
    input wire logic             tx_ready_i,
    input wire logic [WIDTH-1:0] rx_data_i,
    input wire logic             rx_valid_i,
    // interrupts
    input wire logic             tx_irq_o,
    input wire logic             rx_irq_o,
    input wire logic             irq_o
);
    logic [15:0] idx;
    logic        cm_wr;
    logic        cm_rd;

    ////////////////////////////////////////////////////////////////
    // commit-edge qualifiers; partial-lane writes are left out on purpose
    assign idx   = avs_address_i[17:2];
    assign cm_wr = avs_write_i && !avs_waitrequest_o && (avs_byteenable_i[1:0] == 2'b11);
    assign cm_rd = avs_read_i && !avs_waitrequest_o;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    // a pending request and the two control writes of interest
    sequence s_req;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence s_tx_hold_off;
        cm_wr && idx == `SFC_IDX_TX_CTRL && !(avs_writedata_i[15] && avs_writedata_i[13]);
    endsequence
    sequence s_tx_ien_off;
        cm_wr && idx == `SFC_IDX_TX_CTRL && !avs_writedata_i[5];
    endsequence

    ////////////////////////////////////////////////////////////////
    a_wait_once: assert property (s_req |=> !avs_waitrequest_o)
        else $error("waitrequest did not drop after one cycle");
    a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    a_idle_wait: assert property (!avs_read_i && !avs_write_i |=> avs_waitrequest_o)
        else $error("waitrequest low without a request");
    a_tx_hold: assert property (tx_valid_o && !tx_ready_i
        && !$past(cm_wr && idx == `SFC_IDX_TX_CTRL && !(avs_writedata_i[15] && avs_writedata_i[13]))
        |=> tx_valid_o && $stable(tx_data_o))
        else $error("tx word changed before it was taken");
    a_tx_flush: assert property (s_tx_hold_off |=> ##1 !tx_valid_o [*3])
        else $error("tx word still offered after flush");
    a_tx_irq_gate: assert property (s_tx_ien_off |=> ##1 !tx_irq_o)
        else $error("tx interrupt high while disabled");
    a_tx_ctrl_read: assert property (cm_rd && idx == `SFC_IDX_TX_CTRL |->
        avs_readdata_o[6] == 1'b0 && avs_readdata_o[12:8] <= DEPTH && avs_readdata_o[31:16] == 16'h0)
        else $error("tx control read shows bad clear bit or level");
    a_rx_ctrl_read: assert property (cm_rd && idx == `SFC_IDX_RX_CTRL |->
        avs_readdata_o[14] == 1'b0 && avs_readdata_o[6] == 1'b0 && avs_readdata_o[12:8] <= DEPTH)
        else $error("rx control read shows bad clear bit or level");
    a_mask_off: assert property (cm_wr && idx == `SFC_IDX_IRQ_MASK && avs_writedata_i[2:0] == 3'h0
        |=> ##1 !irq_o)
        else $error("summary interrupt high with all sources masked");
endmodule

bind sfc_top sfc_assertions #(.DEPTH(DEPTH), .WIDTH(WIDTH)) u_sfc_assertions (
    .clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_byteenable_i(avs_byteenable_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .tx_data_o(tx_data_o),
    .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i),
    .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o), .irq_o(irq_o));

// ---- tb_top.sv ----
// Purpose: self-checking bench of the queue control block
// Assumes: one wait cycle per access, design defaults
// Notes:   queues model tx and rx words, register values by hand
`timescale 1ns/1ps
`include "sfc_params.svh"
module tb_top
    import sfc_pkg::*;
();
    logic        clk_i;
    logic        rstn_i;
    logic [17:0] avs_address_i;
    logic        avs_read_i;
    logic        avs_write_i;
    logic [3:0]  avs_byteenable_i;
    logic [31:0] avs_writedata_i;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic [7:0]  tx_data_o;
    logic        tx_valid_o;
    logic        tx_ready_i;
    logic [7:0]  rx_data_i;
    logic        rx_valid_i;
    logic        tx_irq_o;
    logic        rx_irq_o;
    logic        irq_o;
    int          miscompares;
    int          check_count;
    logic [7:0]  txq[$];
    logic [7:0]  rxq[$];
    bit          tx_off;
    bit          rx_off;
    int          rx_cap = 4;

    sfc_top u_sfc_top (
        .clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_byteenable_i(avs_byteenable_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .tx_data_o(tx_data_o),
        .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i),
        .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o), .irq_o(irq_o));

    always #2.5 clk_i = ~clk_i;

    ////////////////////////////////////////////////////////////////
    // comparison and end of run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // bus master: hold until waitrequest low, then one idle edge
    task automatic bus(input logic w, input logic [15:0] ix, input logic [31:0] wd, output logic [31:0] rd);
        avs_address_i   <= {ix, 2'b00};
        avs_write_i     <= w;
        avs_read_i      <= !w;
        avs_writedata_i <= wd;
        do
        begin
            @(posedge clk_i);
        end
        while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [15:0] ix, input logic [31:0] wd);
        logic [31:0] d;
        bus(1'b1, ix, wd, d);
    endtask

    task automatic rchk(input logic [15:0] ix, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, ix, 32'h0, d);
        chk(d, exp);
    endtask

    // tx words go to the model only if the queue is running
    task automatic txp(input int n);
        logic [31:0] d;
        for (int i = 0; i < n; i++)
        begin
            d = $urandom;
            wr(`SFC_IDX_TX_DATA, d);
            if (!tx_off)
                txq.push_back(d[7:0]);
        end
    endtask

    // rx words overwrite the oldest once the model is full
    task automatic rxin(input int n);
        logic [7:0] d;
        for (int i = 0; i < n; i++)
        begin
            d = 8'($urandom);
            rx_data_i  <= d;
            rx_valid_i <= 1'b1;
            @(posedge clk_i);
            if (!rx_off && rxq.size() == rx_cap)
                void'(rxq.pop_front());
            if (!rx_off)
                rxq.push_back(d);
        end
        rx_valid_i <= 1'b0;
        rx_data_i  <= ~d;
        @(posedge clk_i);
    endtask

    // every word taken by the shifter must be the oldest modelled one
    always @(posedge clk_i)
    begin
        if (rstn_i && tx_valid_o === 1'b1 && tx_ready_i === 1'b1)
            chk({24'h0, tx_data_o}, txq.size() ? {24'h0, txq.pop_front()} : 32'hx);
    end

    // a hang is cut short here
    initial
    begin
        repeat (20000) @(posedge clk_i);
        chk(32'h0, 32'h1);
        close_out();
    end

    ////////////////////////////////////////////////////////////////
    initial
    begin
        clk_i = 1'b0; rstn_i = 1'b0; avs_address_i = 18'h0; avs_read_i = 1'b0; avs_write_i = 1'b0;
        avs_byteenable_i = 4'hf; avs_writedata_i = 32'h0; tx_ready_i = 1'b0; rx_data_i = 8'h0; rx_valid_i = 1'b0;
        void'($urandom(32'hda25bec0));
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        rchk(`SFC_IDX_TX_CTRL, 32'ha000);
        rchk(`SFC_IDX_RX_CTRL, 32'h201f);
        rchk(`SFC_IDX_IRQ_MASK, 32'h0);
        rchk(`SFC_IDX_IRQ_STAT, 32'h0);
        rchk(16'h7070, 32'h0);
        $display("test reset done");
        // level, flag, clear and enable of the tx queue
        wr(`SFC_IDX_IRQ_MASK, 32'h7);
        wr(`SFC_IDX_TX_CTRL, 32'he000);
        rchk(`SFC_IDX_TX_CTRL, 32'he080);
        chk({31'h0, tx_irq_o}, 32'h0);
        txp(5);
        rchk(`SFC_IDX_TX_CTRL, 32'he480);
        wr(`SFC_IDX_TX_CTRL, 32'he040);
        rchk(`SFC_IDX_TX_CTRL, 32'he400);
        wr(`SFC_IDX_TX_CTRL, 32'he080);
        rchk(`SFC_IDX_TX_CTRL, 32'he400);
        wr(`SFC_IDX_TX_CTRL, 32'he024);
        rchk(`SFC_IDX_TX_CTRL, 32'he4a4);
        chk({31'h0, tx_irq_o}, 32'h1);
        tx_ready_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        chk(32'(txq.size()), 32'h0);
        rchk(`SFC_IDX_TX_CTRL, 32'he0a4);
        chk({31'h0, irq_o}, 32'h1);
        rchk(`SFC_IDX_IRQ_STAT, 32'h1);
        rchk(`SFC_IDX_IRQ_STAT, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        $display("test tx done");
        // pointer reset, then channel reset with config kept
        tx_ready_i <= 1'b0;
        txp(3);
        wr(`SFC_IDX_TX_CTRL, 32'hc024);
        tx_off = 1;
        txq.delete();
        txp(1);
        rchk(`SFC_IDX_TX_CTRL, 32'hc0a4);
        chk({31'h0, tx_valid_o}, 32'h0);
        wr(`SFC_IDX_TX_CTRL, 32'he024);
        tx_off = 0;
        txp(2);
        rxin(2);
        wr(`SFC_IDX_TX_CTRL, 32'h6024);
        txq.delete();
        rxq.delete();
        rchk(`SFC_IDX_TX_CTRL, 32'h60a4);
        rchk(`SFC_IDX_RX_CTRL, 32'h201f);
        wr(`SFC_IDX_TX_CTRL, 32'he024);
        $display("test flush done");
        // rx overrun, level, flag and data order
        wr(`SFC_IDX_RX_CTRL, 32'h2022);
        rxin(5);
        rchk(`SFC_IDX_RX_CTRL, 32'ha4a2);
        chk({31'h0, rx_irq_o}, 32'h1);
        rchk(`SFC_IDX_IRQ_STAT, 32'h6);
        for (int i = 0; i < 4; i++)
            rchk(`SFC_IDX_RX_DATA, {24'h0, rxq.pop_front()});
        wr(`SFC_IDX_RX_CTRL, 32'h6022);
        rchk(`SFC_IDX_RX_CTRL, 32'h20a2);
        wr(`SFC_IDX_RX_CTRL, 32'h2062);
        rchk(`SFC_IDX_RX_CTRL, 32'h2022);
        chk({31'h0, rx_irq_o}, 32'h0);
        wr(`SFC_IDX_RX_CTRL, 32'h0022);
        rx_off = 1;
        rxin(2);
        rchk(`SFC_IDX_RX_CTRL, 32'h0022);
        wr(`SFC_IDX_RX_CTRL, 32'h2022);
        rx_off = 0;
        // single-word buffering with the enhancements off
        wr(`SFC_IDX_TX_CTRL, 32'ha024);
        rx_cap = 1;
        rxin(2);
        rchk(`SFC_IDX_RX_CTRL, 32'ha122);
        rchk(`SFC_IDX_RX_DATA, {24'h0, rxq.pop_front()});
        wr(`SFC_IDX_IRQ_MASK, 32'h0);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h0);
        $display("test rx done");
        close_out();
    end
endmodule
